// File: erb_embedded_ram_block.sv
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "erb_params.svh"
module erb_embedded_ram_block
  import erb_pkg::*;
#(
  parameter int DATA_W = `ERB_DATA_W,
  parameter int ADDR_W = `ERB_ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ERB_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clears
  input wire logic localClr,
  input wire logic globalClr,
  // Write section
  input wire logic wrCe,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Read section
  input wire logic rdCe,
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  // ****************************************************
  // Shape decoding
  // ****************************************************
  function automatic logic [`ERB_WORD_AW-1:0] wordIdx(
    input logic [ADDR_W-1:0] a, input logic [1:0] s);
    logic [ADDR_W-1:0] sh;
    sh = a >> s;
    return sh[`ERB_WORD_AW-1:0];
  endfunction

  function automatic logic [3:0] laneShift(
    input logic [ADDR_W-1:0] a, input logic [1:0] s);
    logic [3:0] r;
    r = 4'h0;
    case (s)
      2'h1: r = {a[0], 3'h0};
      2'h2: r = {a[1:0], 2'h0};
      2'h3: r = {a[2:0], 1'h0};
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] laneMask(input logic [1:0] s);
    logic [DATA_W-1:0] m;
    case (s)
      2'h1: m = 16'h00FF;
      2'h2: m = 16'h000F;
      2'h3: m = 16'h0003;
      default: m = 16'hFFFF;
    endcase
    return m;
  endfunction

  // ****************************************************
  // Configuration registers
  // ****************************************************
  erb_cfg_t cfg_r, cfg_nxt;
  logic [`ERB_WORD_AW-1:0] loadAddr_r, loadAddr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic apbWr, apbSetup, mapped, loadStb;

  assign apbWr = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;
  assign mapped = (paddr == `ERB_OFS_CFG) || (paddr == `ERB_OFS_LOAD_ADDR)
    || (paddr == `ERB_OFS_LOAD_DATA) || (paddr == `ERB_OFS_STATUS);
  assign loadStb = apbWr && paddr == `ERB_OFS_LOAD_DATA && cfg_r.romMode;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;

  always_comb begin
    cfg_nxt = cfg_r;
    loadAddr_nxt = loadAddr_r;
    prdata_nxt = prdata_r;
    if (apbWr && paddr == `ERB_OFS_CFG) begin
      cfg_nxt = erb_cfg_t'(pwdata[`ERB_CFG_W-1:0]);
    end
    if (apbWr && paddr == `ERB_OFS_LOAD_ADDR) begin
      loadAddr_nxt = pwdata[`ERB_WORD_AW-1:0];
    end else if (loadStb) begin
      loadAddr_nxt = loadAddr_r + 8'h01;
    end
    if (apbSetup && !pwrite) begin
      case (paddr)
        `ERB_OFS_CFG: prdata_nxt = {21'h0, cfg_r};
        `ERB_OFS_LOAD_ADDR: prdata_nxt = {24'h0, loadAddr_r};
        `ERB_OFS_STATUS: prdata_nxt = {16'h0, rdData};
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= erb_cfg_t'(`ERB_CFG_RST);
      loadAddr_r <= 8'h00;
      prdata_r <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      loadAddr_r <= loadAddr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ****************************************************
  // Port registers
  // ****************************************************
  logic clrAll;
  logic inRdCe;
  erb_wr_req_t wrIn_r, wrIn_nxt, wrEff;
  erb_rd_req_t rdIn_r, rdIn_nxt, rdEff;
  logic [DATA_W-1:0] dout_r, dout_nxt, readLane;

  assign clrAll = rst | localClr | globalClr;
  // Read-side inputs follow the write enable in the split arrangement
  assign inRdCe = cfg_r.clkArr ? wrCe : rdCe;

  always_comb begin
    wrIn_nxt = wrIn_r;
    rdIn_nxt = rdIn_r;
    dout_nxt = dout_r;
    if (wrCe) begin
      wrIn_nxt = '{en: wrEn, addr: wrAddr, data: wrData};
    end
    if (inRdCe) begin
      rdIn_nxt = '{en: rdEn, addr: rdAddr};
    end
    if (rdCe && rdEff.en) begin
      dout_nxt = readLane;
    end
  end

  always_ff @(posedge clk) begin
    if (clrAll) begin
      wrIn_r <= '0;
      rdIn_r <= '0;
      dout_r <= '0;
    end else begin
      wrIn_r <= wrIn_nxt;
      rdIn_r <= rdIn_nxt;
      dout_r <= dout_nxt;
    end
  end

  // ****************************************************
  // Path selection
  // ****************************************************
  always_comb begin
    // Each path picks its register or the live input, except the single-port read address, which takes the write address
    wrEff.data = cfg_r.regSel[`ERB_REG_DIN] ? wrIn_r.data : wrData;
    wrEff.addr = cfg_r.regSel[`ERB_REG_WADDR] ? wrIn_r.addr : wrAddr;
    wrEff.en = cfg_r.regSel[`ERB_REG_WE] ? wrIn_r.en : wrEn;
    rdEff.addr = cfg_r.regSel[`ERB_REG_RADDR] ? rdIn_r.addr : rdAddr;
    rdEff.en = cfg_r.regSel[`ERB_REG_RE] ? rdIn_r.en : rdEn;
    if (!cfg_r.dualPort) begin
      rdEff.addr = wrEff.addr;
    end
  end

  assign rdData = cfg_r.regSel[`ERB_REG_DOUT] ? dout_r :
    (rdEff.en ? readLane : '0);

  // ****************************************************
  // Array access
  // ****************************************************
  logic userWr, arrWe;
  logic [`ERB_WORD_AW-1:0] arrWAddr;
  logic [DATA_W-1:0] arrWData, arrMask, arrRData, lanePlaced;
  logic [3:0] wShift, rShift;

  // Single write pulse, gated by the write enable; a table
  // in lookup mode refuses user writes
  assign userWr = wrEff.en & wrCe & ~cfg_r.romMode;
  assign arrWe = userWr | loadStb;
  assign wShift = laneShift(wrEff.addr, cfg_r.shape);
  assign rShift = laneShift(rdEff.addr, cfg_r.shape);
  assign lanePlaced = (wrEff.data & laneMask(cfg_r.shape)) << wShift;
  assign arrWAddr = loadStb ? loadAddr_r : wordIdx(wrEff.addr, cfg_r.shape);
  assign arrWData = loadStb ? pwdata[DATA_W-1:0] : lanePlaced;
  assign arrMask = loadStb ? 16'hFFFF : laneMask(cfg_r.shape) << wShift;
  // Narrow shapes return data in the low bits, upper bits zero
  assign readLane = (arrRData >> rShift) & laneMask(cfg_r.shape);

  // Address is full 11 bits so the 2-bit shape reaches 2048
  // words; width doubling is a side-by-side instance
  erb_ram_array #(
    .WORDS(`ERB_WORDS),
    .AW(`ERB_WORD_AW),
    .DW(DATA_W)
  ) u_array (
    .clk(clk),
    .we(arrWe),
    .waddr(arrWAddr),
    .wdata(arrWData),
    .wmask(arrMask),
    .raddr(wordIdx(rdEff.addr, cfg_r.shape)),
    .rdata(arrRData)
  );

  // ****************************************************
  // Checks
  // ****************************************************
  no_write_idle_a: assert property (
    @(posedge clk) disable iff (rst) !wrCe && !loadStb |-> !arrWe)
    else $error("array written while write enable low");

  rom_locked_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_r.romMode && !loadStb |-> !arrWe)
    else $error("user write in lookup mode");

  clear_dout_a: assert property (
    @(posedge clk) disable iff (rst)
    localClr || globalClr |=> dout_r == '0 && wrIn_r == '0)
    else $error("clear did not zero registers");

  dout_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !rdCe && !clrAll ##1 !clrAll |-> $stable(dout_r))
    else $error("output register moved while disabled");

  wr_reg_a: assert property (
    @(posedge clk) disable iff (rst)
    wrCe && !localClr && !globalClr |=> wrIn_r.addr == $past(wrAddr))
    else $error("write address not captured");

  single_addr_a: assert property (
    @(posedge clk) disable iff (rst)
    !cfg_r.dualPort |-> rdEff.addr == wrEff.addr)
    else $error("single-port read address differs");

  split_ce_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_r.clkArr && wrCe && !rdCe && !clrAll |=>
    rdIn_r.addr == $past(rdAddr))
    else $error("read inputs ignored input-side enable");

  load_step_a: assert property (
    @(posedge clk) disable iff (rst)
    loadStb |=> loadAddr_r == $past(loadAddr_r) + 8'h01)
    else $error("load address did not advance");

  narrow_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_r.shape == 2'h3 |-> readLane[DATA_W-1:2] == '0)
    else $error("narrow read has upper bits set");

  apb_err_a: assert property (
    @(posedge clk) disable iff (rst)
    psel && penable && !mapped |-> pready && pslverr)
    else $error("unmapped access not flagged");

  cfg_write_a: assert property (
    @(posedge clk) disable iff (rst)
    apbWr && paddr == `ERB_OFS_CFG |=>
    {21'h0, cfg_r} == ($past(pwdata) & 32'h7FF))
    else $error("configuration write not stored");

  status_read_a: assert property (
    @(posedge clk) disable iff (rst)
    apbSetup && !pwrite && paddr == `ERB_OFS_STATUS |=>
    prdata == {16'h0, $past(rdData)})
    else $error("status read did not capture output");

  err_clean_a: assert property (
    @(posedge clk) disable iff (rst)
    psel && penable && !mapped |=> $stable(cfg_r) && $stable(loadAddr_r))
    else $error("unmapped access changed a register");

  dout_load_a: assert property (
    @(posedge clk) disable iff (rst)
    rdCe && rdEff.en && !clrAll |=> dout_r == $past(readLane))
    else $error("output register missed a read");

  wr_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !wrCe && !clrAll |=> $stable(wrIn_r))
    else $error("write inputs moved while disabled");

  rd_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !inRdCe && !clrAll |=> $stable(rdIn_r))
    else $error("read inputs moved while disabled");

  wr_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    arrWe && !loadStb |-> wrCe && wrEff.en)
    else $error("write pulse without enabled request");

  lane_clean_a: assert property (
    @(posedge clk) disable iff (rst)
    arrWe |-> (arrWData & ~arrMask) == '0)
    else $error("write data outside selected lane");

  byte_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_r.shape == 2'h1 |-> readLane[DATA_W-1:8] == '0)
    else $error("byte read has upper bits set");

endmodule // erb_embedded_ram_block

// File: erb_fabric_model.sv
`timescale 1ns/1ns
module erb_fabric_model (
  // Clock
  input wire logic clk,
  // Write section
  output logic wrCe,
  output logic wrEn,
  output logic [10:0] wrAddr,
  output logic [15:0] wrData,
  // Read section
  output logic rdCe,
  output logic rdEn,
  output logic [10:0] rdAddr,
  input wire logic [15:0] rdData
);
  initial begin
    wrCe = 1'b1;
    wrEn = 1'b0;
    wrAddr = 11'h000;
    wrData = 16'h0000;
    rdCe = 1'b1;
    rdEn = 1'b0;
    rdAddr = 11'h000;
  end

  // ****************************************
  // Write, held two edges for any path setup
  // ****************************************
  task automatic wr(input logic [10:0] a, input logic [15:0] d,
                    input logic ce);
    @(posedge clk);
    wrCe <= ce;
    wrEn <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    repeat (2) @(posedge clk);
    wrCe <= 1'b1;
    wrEn <= 1'b0;
    // Released lines never keep the old value
    wrAddr <= ~a;
    wrData <= ~d;
  endtask

  // ****************************************
  // Read, sampled once the output has settled
  // ****************************************
  task automatic rd(input logic [10:0] a, output logic [15:0] q);
    @(posedge clk);
    rdEn <= 1'b1;
    rdAddr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    q = rdData;
    @(posedge clk);
    rdEn <= 1'b0;
    rdAddr <= ~a;
  endtask

  // Read-section enable on its own, for hold tests
  task automatic ceRd(input logic v);
    @(posedge clk);
    rdCe <= v;
  endtask
endmodule // erb_fabric_model

// File: erb_params.svh
`ifndef ERB_PARAMS_SVH
`define ERB_PARAMS_SVH

// ****************************************************
// Geometry
// ****************************************************
`define ERB_DATA_W 16
`define ERB_ADDR_W 11
`define ERB_WORDS 256
`define ERB_WORD_AW 8
`define ERB_SHAPE_W 2

// ****************************************************
// Register offsets (byte addresses)
// ****************************************************
`define ERB_APB_AW 8
`define ERB_OFS_CFG 8'h00
`define ERB_OFS_LOAD_ADDR 8'h04
`define ERB_OFS_LOAD_DATA 8'h08
`define ERB_OFS_STATUS 8'h0C

// ****************************************************
// Configuration fields and reset value
// ****************************************************
`define ERB_CFG_W 11
`define ERB_REG_DIN 0
`define ERB_REG_DOUT 1
`define ERB_REG_WADDR 2
`define ERB_REG_WE 3
`define ERB_REG_RADDR 4
`define ERB_REG_RE 5
`define ERB_CFG_RST 11'h7E4

`endif

// File: erb_pkg.sv
`include "erb_params.svh"

package erb_pkg;

  // Configuration word: path register selects, modes, shape
  typedef struct packed {
    logic [5:0] regSel;
    logic romMode;
    logic clkArr;
    logic dualPort;
    logic [`ERB_SHAPE_W-1:0] shape;
  } erb_cfg_t;

  typedef struct packed {
    logic en;
    logic [`ERB_ADDR_W-1:0] addr;
    logic [`ERB_DATA_W-1:0] data;
  } erb_wr_req_t;

  typedef struct packed {
    logic en;
    logic [`ERB_ADDR_W-1:0] addr;
  } erb_rd_req_t;

endpackage

// File: erb_ram_array.sv
`timescale 1ns/1ns
`include "erb_params.svh"
module erb_ram_array #(
  parameter int WORDS = `ERB_WORDS,
  parameter int AW = `ERB_WORD_AW,
  parameter int DW = `ERB_DATA_W
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [DW-1:0] wmask,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // ****************************************************
  // Storage: fixed bit count, shape decided outside
  // ****************************************************
  logic [DW-1:0] mem [WORDS];
  logic [DW-1:0] memNxt;

  always_comb begin
    memNxt = (mem[waddr] & ~wmask) | (wdata & wmask);
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= memNxt;
    end
  end

  assign rdata = mem[raddr];

endmodule // erb_ram_array

// File: test_erb_embedded_ram_block.sv
`timescale 1ns/1ns
module test_erb_embedded_ram_block;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, pe;
  logic localClr, globalClr, wrCe, wrEn, rdCe, rdEn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [10:0] wrAddr, rdAddr;
  logic [10:0] wa [6];
  logic [15:0] wrData, rdData, q;
  logic [15:0] wd [6];
  int n_mismatch = 0;
  int samples_checked = 0;

  erb_embedded_ram_block u_erb_embedded_ram_block (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .localClr, .globalClr, .wrCe, .wrEn, .wrAddr, .wrData, .rdCe,
    .rdEn, .rdAddr, .rdData);
  erb_fabric_model u_erb_fabric_model (.clk, .wrCe, .wrEn, .wrAddr,
    .wrData, .rdCe, .rdEn, .rdAddr, .rdData);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] mask(int s);
    return 16'hFFFF >> (16 - (16 >> s));
  endfunction

  // Last data written to the address of entry i
  function automatic logic [15:0] latest(int i, int s);
    logic [15:0] e;
    e = wd[i];
    for (int j = i + 1; j < 6; j++) begin
      if (wa[j] == wa[i]) begin
        e = wd[j];
      end
    end
    return e & mask(s);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #2000000;
    n_mismatch++;
    print_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'hDF3C));
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    localClr = 1'b0;
    globalClr = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rv, 32'h7E4);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, pe}, 32'h1);
    chk(rv, 32'h0);
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 2; r++) begin
        apb(1'b1, 8'h00, {21'h0, r ? 6'h3F : 6'h00, 1'b0, s[0],
            1'b1, s[1:0]});
        for (int i = 0; i < 6; i++) begin
          wa[i] = (i == 0) ? 11'((256 << s) - 1)
            : 11'($urandom_range((256 << s) - 1));
          wd[i] = 16'($urandom);
          u_erb_fabric_model.wr(wa[i], wd[i], 1'b1);
        end
        for (int i = 0; i < 6; i++) begin
          u_erb_fabric_model.rd(wa[i], q);
          chk({16'h0, q}, {16'h0, latest(i, s)});
        end
      end
    end
    // Single port: the read follows the parked write address
    apb(1'b1, 8'h00, 32'h0);
    u_erb_fabric_model.wr(11'h0AA, 16'h1357, 1'b1);
    u_erb_fabric_model.wr(11'h055, 16'h2468, 1'b1);
    u_erb_fabric_model.rd(11'h055, q);
    chk({16'h0, q}, 32'h1357);
    apb(1'b1, 8'h00, 32'h7E4);
    u_erb_fabric_model.wr(11'h005, 16'h1234, 1'b1);
    u_erb_fabric_model.wr(11'h005, 16'hBEEF, 1'b0);
    u_erb_fabric_model.rd(11'h005, q);
    chk({16'h0, q}, 32'h1234);
    u_erb_fabric_model.ceRd(1'b0);
    apb(1'b1, 8'h00, 32'h7EC);
    u_erb_fabric_model.wr(11'h006, 16'h4321, 1'b1);
    u_erb_fabric_model.rd(11'h006, q);
    chk({16'h0, q}, 32'h1234);
    u_erb_fabric_model.ceRd(1'b1);
    u_erb_fabric_model.rd(11'h006, q);
    chk({16'h0, q}, 32'h4321);
    for (int c = 0; c < 2; c++) begin
      u_erb_fabric_model.rd(11'h005, q);
      @(posedge clk);
      localClr <= (c == 0);
      globalClr <= (c == 1);
      @(posedge clk);
      localClr <= 1'b0;
      globalClr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({16'h0, rdData}, 32'h0);
    end
    apb(1'b1, 8'h00, 32'h7F4);
    apb(1'b1, 8'h04, 32'h10);
    apb(1'b1, 8'h08, 32'hCAFE);
    apb(1'b1, 8'h08, 32'h5A5A);
    u_erb_fabric_model.wr(11'h010, 16'h0000, 1'b1);
    u_erb_fabric_model.rd(11'h010, q);
    chk({16'h0, q}, 32'hCAFE);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rv, 32'hCAFE);
    u_erb_fabric_model.rd(11'h011, q);
    chk({16'h0, q}, 32'h5A5A);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rv, 32'h7E4);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rv, 32'h0);
    print_verdict();
  end
endmodule // test_erb_embedded_ram_block
